// ==== rtl/arch_map_pkg.sv ====
// Constants, types and helpers for the architected address decode.
package arch_map_pkg;

  // Bus widths; data uses bit 0 as the most significant bit.
  localparam int ADDR_W = 48;
  localparam int DATA_W = 32;
  localparam int BYTES_W = 4;

  // Page size and the address bits that select a word inside a page.
  localparam int PAGE_BYTES = 4096;
  localparam int PAGE_SHIFT = 12;
  localparam int WORD_SHIFT = 2;

  // Prefix of the top 4 GB and of the 16 MB architected window.
  localparam logic [15:0] TOP_PREFIX = 16'hffff;
  localparam logic [7:0] ARCH_PREFIX = 8'hff;

  // Page numbers inside the 16 MB window.
  localparam logic [11:0] PG_ARCH_REGS = 12'h000;
  localparam logic [11:0] PG_CTRL_RAM = 12'h001;
  localparam logic [11:0] PG_UNIMPL0_LO = 12'h002;
  localparam logic [11:0] PG_UNIMPL0_HI = 12'h0ff;
  localparam logic [11:0] PG_UNIMPL1_LO = 12'h183;
  localparam logic [11:0] PG_UNIMPL1_HI = 12'h1ff;
  localparam logic [11:0] PG_UNIMPL2_LO = 12'h202;
  localparam logic [11:0] PG_UNIMPL2_HI = 12'h2ff;
  localparam logic [11:0] PG_UNIMPL3_LO = 12'h800;
  localparam logic [11:0] PG_UNIMPL3_HI = 12'h9ff;
  localparam logic [11:0] PG_UNIMPL4_LO = 12'hc00;
  localparam logic [11:0] PG_UNIMPL4_HI = 12'hdff;

  // Implemented words in the register page and the control block RAM.
  localparam logic [9:0] ARCH_REG_COUNT = 10'h004;
  localparam logic [9:0] RAM_WORDS = 10'h040;

  // Bits 0..15 of each register are implemented, 16..31 reserved.
  localparam logic [0:31] ARCH_IMPL_MASK = 32'hffff0000;
  localparam logic [0:31] ARCH_RESET = 32'h00000000;

  // Decoded target of one access.
  typedef enum logic [2:0] {
    RGN_OUTSIDE = 3'b000,
    RGN_FOREIGN = 3'b001,
    RGN_ARCH = 3'b010,
    RGN_RAM = 3'b011,
    RGN_UNIMPL = 3'b100
  } region_t;

  // Replace the byte lanes that are enabled; lane 0 is bits 0..7.
  function automatic logic [0:31] merge_bytes(input logic [0:31] old_v,
                                              input logic [0:31] new_v,
                                              input logic [0:3] be);
    logic [0:31] r;
    r = old_v;
    for (int k = 0; k < BYTES_W; k++) begin
      if (be[k]) begin
        r[8*k +: 8] = new_v[8*k +: 8];
      end
    end
    return r;
  endfunction

  // True when the page lies in any unimplemented range.
  function automatic logic pg_unimpl(input logic [11:0] pg);
    return (pg >= PG_UNIMPL0_LO && pg <= PG_UNIMPL0_HI) ||
           (pg >= PG_UNIMPL1_LO && pg <= PG_UNIMPL1_HI) ||
           (pg >= PG_UNIMPL2_LO && pg <= PG_UNIMPL2_HI) ||
           (pg >= PG_UNIMPL3_LO && pg <= PG_UNIMPL3_HI) ||
           (pg >= PG_UNIMPL4_LO && pg <= PG_UNIMPL4_HI);
  endfunction

endpackage

// ==== rtl/addr_decode_if.sv ====
// Interface between the access logic and the address region decoder.
`timescale 1ns/10ps
interface addr_decode_if;
  import arch_map_pkg::*;
  logic [ADDR_W-1:0] addr;
  arch_map_pkg::region_t region;
  logic [9:0] word;

  modport requester (output addr, input region, input word);
  modport decoder (input addr, output region, output word);
endinterface

// ==== rtl/addr_region_decoder.sv ====
// Page based region decoder for the architected address window.
`timescale 1ns/10ps
module addr_region_decoder
  import arch_map_pkg::*;
(
  // Decode request and result.
  addr_decode_if.decoder dec
);

  wire [11:0] page_idx;
  wire [9:0] word_idx;
  wire in_top;
  wire in_arch;
  region_t next_region;

  // Only the top 4 GB of the 48-bit space holds architected facilities,
  // so the upper 16 real address bits must be all ones.
  assign in_top = (dec.addr[47:32] == TOP_PREFIX);
  assign in_arch = in_top && (dec.addr[31:24] == ARCH_PREFIX);
  assign page_idx = dec.addr[23:PAGE_SHIFT];
  assign word_idx = dec.addr[PAGE_SHIFT-1:WORD_SHIFT];

  // Words past the implemented count inside a live page count as
  // unimplemented, so they never alias onto real storage.
  assign next_region =
    !in_top ? RGN_OUTSIDE :
    !in_arch ? RGN_FOREIGN :
    (page_idx == PG_ARCH_REGS) ?
      ((word_idx < ARCH_REG_COUNT) ? RGN_ARCH : RGN_UNIMPL) :
    (page_idx == PG_CTRL_RAM) ?
      ((word_idx < RAM_WORDS) ? RGN_RAM : RGN_UNIMPL) :
    pg_unimpl(page_idx) ? RGN_UNIMPL : RGN_FOREIGN;

  assign dec.region = next_region;
  assign dec.word = word_idx;

endmodule

// ==== rtl/arch_addr_space.sv ====
// Architected address window slave with reserved-bit handling.
`timescale 1ns/10ps
module arch_addr_space
  import arch_map_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  // Access request from the system bus.
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire logic [ADDR_W-1:0] req_addr_i,
  input wire logic [0:31] req_wdata_i,
  input wire logic [0:3] req_be_i,
  // Access response.
  output logic rsp_valid_o,
  output logic rsp_claim_o,
  output logic rsp_outside_o,
  output logic [0:31] rsp_rdata_o,
  // Implemented bits of the first architected register.
  output logic [0:31] ctrl_o
);

  addr_decode_if dec_bus ();

  addr_region_decoder u_dec (
    .dec(dec_bus.decoder)
  );

  logic [0:31] arch_reg [0:3];
  logic [0:31] ctrl_ram [0:63];
  wire region_t rgn;
  wire [1:0] reg_sel;
  wire [5:0] ram_sel;
  wire wr_arch;
  wire wr_ram;
  wire [0:31] arch_merged;
  wire [0:31] ram_merged;
  wire [0:31] next_rdata;

  // Decode is combinational, so the answer stays at one cycle.
  assign dec_bus.addr = req_addr_i;
  assign rgn = dec_bus.region;
  assign reg_sel = dec_bus.word[1:0];
  assign ram_sel = dec_bus.word[5:0];

  // Write strobes; unimplemented and foreign targets get none.
  assign wr_arch = req_valid_i && req_write_i && (rgn == RGN_ARCH);
  assign wr_ram = req_valid_i && req_write_i && (rgn == RGN_RAM);

  // Byte lanes merge big-endian; reserved register bits are never stored,
  // so a non-zero write there is simply lost.
  assign arch_merged =
    merge_bytes(arch_reg[reg_sel], req_wdata_i, req_be_i)
    & ARCH_IMPL_MASK;
  assign ram_merged =
    merge_bytes(ctrl_ram[ram_sel], req_wdata_i, req_be_i);

  // Read data by region; everything without storage reads zero.
  assign next_rdata =
    (rgn == RGN_ARCH) ? (arch_reg[reg_sel] & ARCH_IMPL_MASK) :
    (rgn == RGN_RAM) ? ctrl_ram[ram_sel] :
    32'h00000000;

  // Architected registers with a defined reset value.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < 4; i++) begin
        arch_reg[i] <= ARCH_RESET;
      end
    end else if (wr_arch) begin
      arch_reg[reg_sel] <= arch_merged;
    end
  end

  // Control block RAM keeps every bit as written; it has no reset,
  // since RAM contents are undefined until software fills them.
  always_ff @(posedge clk_sys_i) begin
    if (wr_ram) begin
      ctrl_ram[ram_sel] <= ram_merged;
    end
  end

  // Response registers: every request gets exactly one answer.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rsp_valid_o <= 1'b0;
      rsp_claim_o <= 1'b0;
      rsp_outside_o <= 1'b0;
      rsp_rdata_o <= 32'h00000000;
    end else begin
      rsp_valid_o <= req_valid_i;
      rsp_claim_o <= req_valid_i && (rgn inside {RGN_ARCH, RGN_RAM,
                                                 RGN_UNIMPL});
      rsp_outside_o <= req_valid_i && (rgn == RGN_OUTSIDE);
      rsp_rdata_o <= (req_valid_i && !req_write_i) ? next_rdata
                                                   : 32'h00000000;
    end
  end

  // Register zero is mirrored out so its implemented bits can steer logic.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_o <= ARCH_RESET;
    end else if (wr_arch && reg_sel == 2'b00) begin
      ctrl_o <= arch_merged;
    end
  end

  // Helper state for the checks below.
  logic rd_unimpl_q;
  logic rd_arch_q;
  logic [0:31] ram_last_q;
  logic [5:0] ram_last_sel_q;
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_unimpl_q <= 1'b0;
      rd_arch_q <= 1'b0;
      ram_last_q <= 32'h00000000;
      ram_last_sel_q <= 6'h00;
    end else begin
      rd_unimpl_q <= req_valid_i && !req_write_i &&
                     (rgn inside {RGN_UNIMPL, RGN_FOREIGN, RGN_OUTSIDE});
      rd_arch_q <= req_valid_i && !req_write_i && (rgn == RGN_ARCH);
      if (wr_ram) begin
        ram_last_q <= ram_merged;
        ram_last_sel_q <= ram_sel;
      end
    end
  end

  a_rsp_one_cycle: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    req_valid_i |=> rsp_valid_o ##1 (rsp_valid_o == $past(req_valid_i)))
    else $error("Response did not follow its request by one cycle.");

  a_idle_no_rsp: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    !req_valid_i |=> !rsp_valid_o && !rsp_claim_o)
    else $error("Response appeared without a request.");

  a_unimpl_read_zero: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    rd_unimpl_q |-> rsp_valid_o && rsp_rdata_o == 32'h00000000)
    else $error("Unimplemented location read back non-zero.");

  a_unimpl_write_drop: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    (req_valid_i && req_write_i && rgn == RGN_UNIMPL)
    |=> $stable(ctrl_o) && $stable(arch_reg[1]) && $stable(arch_reg[2]) &&
        $stable(arch_reg[3]))
    else $error("Write to unimplemented location changed state.");

  a_arch_rsv_zero: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    rd_arch_q |-> (rsp_rdata_o & ~ARCH_IMPL_MASK) == 32'h00000000)
    else $error("Reserved register bits read back non-zero.");

  a_ram_echo: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    (wr_ram ##1 (req_valid_i && !req_write_i && rgn == RGN_RAM &&
                 ram_sel == ram_last_sel_q))
    |=> rsp_rdata_o == ram_last_q)
    else $error("Control block RAM did not echo the last write.");

  a_outside_flag: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    (req_valid_i && req_addr_i[47:32] != TOP_PREFIX)
    |=> rsp_outside_o && !rsp_claim_o)
    else $error("Access below the top 4 GB was not flagged outside.");

  a_msb_lane: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    (wr_arch && reg_sel == 2'b00 && req_be_i == 4'h8)
    |=> ctrl_o[8:31] == $past(arch_reg[0][8:31])
        && ctrl_o[0:7] == $past(req_wdata_i[0:7]))
    else $error("Byte lane 0 did not map to bits 0 to 7.");

  // These work from the raw address rather than from the decoder's result,
  // so a slip inside the region decoder cannot hide behind its own output.
  a_arch_claim: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    (req_valid_i && req_addr_i[47:24] == {TOP_PREFIX, ARCH_PREFIX} &&
     req_addr_i[23:12] == PG_ARCH_REGS &&
     req_addr_i[11:2] < ARCH_REG_COUNT)
    |=> rsp_valid_o && rsp_claim_o && !rsp_outside_o)
    else $error("Implemented register word was not claimed.");

  a_unimpl_claim: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    (req_valid_i && req_addr_i[47:24] == {TOP_PREFIX, ARCH_PREFIX} &&
     pg_unimpl(req_addr_i[23:12]))
    |=> rsp_claim_o && rsp_rdata_o == 32'h00000000)
    else $error("Unimplemented page was not claimed with zero data.");

  a_foreign_quiet: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    (req_valid_i && req_addr_i[47:32] == TOP_PREFIX &&
     req_addr_i[31:24] != ARCH_PREFIX)
    |=> rsp_valid_o && !rsp_claim_o && !rsp_outside_o)
    else $error("Access outside the window was claimed or flagged.");

  // A write answer must never leak stale read data onto the bus.
  a_write_no_data: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    (req_valid_i && req_write_i) |=> rsp_rdata_o == 32'h00000000)
    else $error("Write response carried read data.");

  a_ctrl_rsv_zero: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    ctrl_o[16:31] == 16'h0000)
    else $error("Reserved bits of the mirrored register were non-zero.");

endmodule

// ==== verif/sys_bus_master.sv ====
// Requester model that stands on the system bus side of the window slave.
`timescale 1ns/10ps
module sys_bus_master
  import arch_map_pkg::*;
(
  // Clock.
  input wire logic clk_sys_i,
  // Request towards the slave.
  output logic req_valid_o,
  output logic req_write_o,
  output logic [ADDR_W-1:0] req_addr_o,
  output logic [0:31] req_wdata_o,
  output logic [0:3] req_be_o,
  // Response from the slave.
  input wire logic rsp_valid_i,
  input wire logic rsp_claim_i,
  input wire logic rsp_outside_i,
  input wire logic [0:31] rsp_rdata_i
);
  // Quiet from time zero so nothing is taken during reset.
  initial begin
    req_valid_o = 1'b0;
    req_write_o = 1'b0;
    req_addr_o = '0;
    req_wdata_o = '0;
    req_be_o = 4'h0;
  end

  // Called at a falling edge; holds across the taking edge and collects
  // the answer a cycle later, so calls chain back to back.
  task automatic access(input logic wr, input logic [ADDR_W-1:0] a,
                        input logic [0:31] d, input logic [0:3] be,
                        output logic [0:34] r);
    req_valid_o = 1'b1;
    req_write_o = wr;
    req_addr_o = a;
    req_wdata_o = d;
    req_be_o = be;
    @(negedge clk_sys_i);
    r = {rsp_valid_i, rsp_claim_i, rsp_outside_i, rsp_rdata_i};
  endtask

  // Released lines do not keep their old value, so stale decode is caught.
  task automatic idle();
    req_valid_o = 1'b0;
    req_write_o = ~req_write_o;
    req_addr_o = ~req_addr_o;
    req_wdata_o = ~req_wdata_o;
    req_be_o = ~req_be_o;
    @(negedge clk_sys_i);
  endtask
endmodule

// ==== verif/reserved_bit_address_decode_tb_top.sv ====
// Self-checking bench for the architected address window slave.
`timescale 1ns/10ps
module reserved_bit_address_decode_tb_top;
  import arch_map_pkg::*;
  logic clk_sys_i = 1'b0;
  logic nrst_i = 1'b0;
  logic rv, rw, sv, sc, so;
  logic [ADDR_W-1:0] ra;
  logic [0:31] wd, rd, ctrl;
  logic [0:3] rb;
  int miscompares = 0;
  int compares = 0;
  int seed = 97;
  logic [0:31] shadow [0:7];
  logic [0:34] r;
  localparam logic [23:0] WIN = 24'hffffff;
  localparam logic [11:0] UNIMPL [0:9] = '{12'h002, 12'h0ff, 12'h183,
    12'h1ff, 12'h202, 12'h2ff, 12'h800, 12'h9ff, 12'hc00, 12'hdff};
  localparam logic [11:0] FOREIGN [0:3] = '{12'h100, 12'h182, 12'h600,
    12'he00};

  always #2.5 clk_sys_i = ~clk_sys_i;

  arch_addr_space dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
    .req_valid_i(rv), .req_write_i(rw), .req_addr_i(ra),
    .req_wdata_i(wd), .req_be_i(rb), .rsp_valid_o(sv), .rsp_claim_o(sc),
    .rsp_outside_o(so), .rsp_rdata_o(rd), .ctrl_o(ctrl));
  sys_bus_master bm (.clk_sys_i(clk_sys_i), .req_valid_o(rv),
    .req_write_o(rw), .req_addr_o(ra), .req_wdata_o(wd), .req_be_o(rb),
    .rsp_valid_i(sv), .rsp_claim_i(sc), .rsp_outside_i(so),
    .rsp_rdata_i(rd));

  // Counts every compare and reports a mismatch at once.
  task automatic check(input logic [0:34] seen, input logic [0:34] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Expected word after a byte-enabled write; lane 0 is the top byte.
  function automatic logic [0:31] lanes(input logic [0:31] o,
      input logic [0:31] n, input logic [0:3] be);
    for (int k = 0; k < 4; k++) begin
      if (be[k]) begin
        o[8*k +: 8] = n[8*k +: 8];
      end
    end
    return o;
  endfunction

  // Expected answer of a decoded access inside the top 4 GB.
  function automatic logic [0:34] ok(input logic c, input logic [0:31] d);
    return {1'b1, c, 1'b0, d};
  endfunction

  // Access inside the 16 MB window by page and page offset.
  task automatic go(input logic wr, input logic [11:0] pg,
      input logic [11:0] off, input logic [0:31] d, input logic [0:3] be);
    bm.access(wr, {WIN, pg, off}, d, be, r);
  endtask

  task automatic results();
    if (miscompares == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // A hang is cut short here and counted.
  initial begin
    #200000;
    miscompares++;
    results();
  end

  initial begin
    logic [0:31] ctl;
    logic [0:31] v;
    logic [0:3] be;
    repeat (3) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    nrst_i = 1'b1;
    check({sv, sc, so, ctrl}, '0);
    // Reserved half written non-zero on purpose; it must read back zero.
    go(1'b1, PG_ARCH_REGS, 12'h000, 32'h12345678, 4'hf);
    check(r, ok(1'b1, 32'h0));
    go(1'b0, PG_ARCH_REGS, 12'h003, 32'h0, 4'hf);
    check(r, ok(1'b1, 32'h12340000));
    check({3'b000, ctrl}, {3'b000, 32'h12340000});
    ctl = 32'h12340000;
    for (int i = 0; i < 8; i++) begin
      v = $random(seed);
      be = 4'($random(seed));
      v[16:31] = 16'h0000;
      go(1'b1, PG_ARCH_REGS, 12'h000, v, be);
      ctl = lanes(ctl, v, be) & ARCH_IMPL_MASK;
      go(1'b0, PG_ARCH_REGS, 12'h000, 32'h0, 4'hf);
      check(r, ok(1'b1, ctl));
      check({3'b000, r[3:34] & ARCH_IMPL_MASK}, {3'b000, ctl});
    end
    // Only lane 0 enabled: the addressed byte must land in bits 0..7.
    go(1'b1, PG_ARCH_REGS, 12'h000, 32'hab000000, 4'h8);
    ctl = lanes(ctl, 32'hab000000, 4'h8) & ARCH_IMPL_MASK;
    check({3'b000, ctrl}, {3'b000, ctl});
    go(1'b1, PG_ARCH_REGS, 12'h00c, 32'hffffffff, 4'hf);
    go(1'b0, PG_ARCH_REGS, 12'h00c, 32'h0, 4'hf);
    check(r, ok(1'b1, 32'hffff0000));
    // Control block RAM keeps every bit, reserved ones included.
    for (int i = 0; i < 24; i++) begin
      v = $random(seed);
      be = (i < 8) ? 4'hf : 4'($random(seed));
      go(1'b1, PG_CTRL_RAM, {4'h0, 6'((i % 8) * 9), 2'b00}, v, be);
      shadow[i % 8] = lanes(shadow[i % 8], v, be);
    end
    for (int i = 0; i < 8; i++) begin
      go(1'b0, PG_CTRL_RAM, {4'h0, 6'(i * 9), 2'b00}, 32'h0, 4'hf);
      check(r, ok(1'b1, shadow[i]));
    end
    // Write then read the same word back to back.
    v = $random(seed);
    go(1'b1, PG_CTRL_RAM, 12'h0fc, v, 4'hf);
    go(1'b0, PG_CTRL_RAM, 12'h0fc, 32'h0, 4'hf);
    check(r, ok(1'b1, v));
    shadow[7] = v;
    // Range edges of unimplemented space, plus past the end of each page.
    for (int i = 0; i < 12; i++) begin
      v = $random(seed);
      if (i < 10) begin
        go(1'b1, UNIMPL[i], 12'($random(seed)) & 12'hffc, v, 4'hf);
      end else begin
        go(1'b1, 12'(i - 10), (i == 10) ? 12'h010 : 12'h100, v, 4'hf);
      end
      go(1'b0, bm.req_addr_o[23:12], bm.req_addr_o[11:0], 32'h0, 4'hf);
      check(r, ok(1'b1, 32'h0));
    end
    // The write past the end of the RAM page must not alias onto word 0.
    go(1'b0, PG_CTRL_RAM, 12'h000, 32'h0, 4'hf);
    check(r, ok(1'b1, shadow[0]));
    for (int i = 0; i < 4; i++) begin
      go(1'b1, FOREIGN[i], 12'h000, 32'hffffffff, 4'hf);
      check(r, ok(1'b0, 32'h0));
    end
    bm.access(1'b1, 48'hffff_fe00_0000, 32'hffffffff, 4'hf, r);
    check(r, ok(1'b0, 32'h0));
    bm.access(1'b1, 48'h0000_ff00_0000, 32'hffffffff, 4'hf, r);
    check(r, {3'b101, 32'h0});
    bm.access(1'b0, 48'h7fff_ff00_0000, 32'h0, 4'hf, r);
    check(r, {3'b101, 32'h0});
    go(1'b0, PG_ARCH_REGS, 12'h000, 32'h0, 4'hf);
    check(r, ok(1'b1, ctl));
    bm.idle();
    check({sv, sc, so, rd}, '0);
    // Reset in mid-run clears the register again.
    nrst_i = 1'b0;
    @(negedge clk_sys_i);
    check({3'b000, ctrl}, {3'b000, ARCH_RESET});
    nrst_i = 1'b1;
    go(1'b0, PG_ARCH_REGS, 12'h000, 32'h0, 4'hf);
    check(r, ok(1'b1, ARCH_RESET));
    bm.idle();
    results();
  end
endmodule
